// ---- jril_pkg.sv ----
// shared constants for the jtag ram init loader
// Contract
// - rams load from fabric or jtag path
// - take command, data, clock from macro
// - write only the addressed ram block
// - one chip select per block, one active
// - selects by ring counter or decode
// - present write address of current word
// - serial bits in, parallel word out
// - write clock samples data, address, select
// - shift register as wide as ram word
// - shift on jtag shift clock only
// - write only after word fully shifted
// - pipeline word to align with address
// - address word via second opcode, register
// - internal counter sweeps address range
package jril_pkg;
  localparam int DATA_W = 8;          // ram word width
  localparam int ADDR_W = 9;          // ram address width
  localparam int BLK_W  = 2;          // block index width
  localparam int NBLK   = 4;          // number of ram blocks
  localparam int LOC_W  = ADDR_W + BLK_W;  // address word width
  localparam int PAY_W  = LOC_W + 1;  // crossing payload width
  localparam int CNT_W  = 4;          // shift bit counter width
  localparam int PAY_KIND = PAY_W - 1;     // payload kind bit position
  localparam int IR_W   = 8;          // user instruction width
  // instruction codes, arbitrary values
  localparam logic [IR_W-1:0] OP_DATA = 8'h10;
  localparam logic [IR_W-1:0] OP_ADDR = 8'h11;
  localparam logic [CNT_W-1:0] DATA_LAST = 4'h7;  // DATA_W - 1
  localparam logic [CNT_W-1:0] LOC_LAST  = 4'hA;  // LOC_W - 1
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 9'h1FF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [NBLK-1:0]   SEL_RESET  = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 4'h0;
endpackage

// ---- jril_word_if.sv ----
// word crossing from the jtag clock domain to the core domain
`timescale 1ns/1ps
interface jril_word_if;
  logic                      tgl;       // toggles once per word
  logic [jril_pkg::PAY_W-1:0] src_word; // held while toggle settles
  logic                      vld;       // one core cycle per word
  logic [jril_pkg::PAY_W-1:0] dst_word; // word in core domain
  modport link (output tgl, output src_word);
  modport xfer (input tgl, input src_word, output vld, output dst_word);
  modport core (input vld, input dst_word);
endinterface

// ---- jril_xfer.sv ----
// toggle handshake that carries one held word into the core clock
`timescale 1ns/1ps
module jril_xfer (
  input wire logic clk,
  input wire logic rst_n,
  jril_word_if.xfer w
);
  logic tgl_s1_reg;  // first sync stage, read only by second
  logic tgl_s2_reg;  // second sync stage
  logic tgl_s3_reg;  // previous value for edge detect
  logic vld_reg;     // word strobe
  logic [jril_pkg::PAY_W-1:0] word_reg;  // captured word

  // synchronise the toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= w.tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // capture the held word on each toggle edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_reg  <= 1'b0;
      word_reg <= '0;
    end else begin
      vld_reg <= tgl_s2_reg ^ tgl_s3_reg;
      if (tgl_s2_reg ^ tgl_s3_reg) begin
        word_reg <= w.src_word;
      end
    end
  end

  assign w.vld      = vld_reg;
  assign w.dst_word = word_reg;
endmodule

// ---- jril_csel.sv ----
// block select register: ring stepping or decoded load
`timescale 1ns/1ps
module jril_csel (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      step,
  input  wire logic                      load,
  input  wire logic [jril_pkg::BLK_W-1:0] load_idx,
  output logic      [jril_pkg::NBLK-1:0]  sel
);
  logic [jril_pkg::NBLK-1:0] dec;       // decoded block index
  logic [jril_pkg::NBLK-1:0] sel_reg;   // one-hot current block
  logic [jril_pkg::NBLK-1:0] sel_next;  // next selection

  // one decoder bit per block
  genvar g;
  generate
    for (g = 0; g < jril_pkg::NBLK; g++) begin : g_dec
      assign dec[g] = (int'(load_idx) == g);
    end
  endgenerate

  // load wins over step, step rotates the ring
  always_comb begin
    sel_next = sel_reg;
    if (load) begin
      sel_next = dec;
    end else if (step) begin
      sel_next = {sel_reg[jril_pkg::NBLK-2:0],
                  sel_reg[jril_pkg::NBLK-1]};
    end
  end

  // hold the selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= jril_pkg::SEL_RESET;
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign sel = sel_reg;
endmodule

// ---- jril_loader.sv ----
// jtag ram init loader: shifts words in on the jtag clock, writes rams
`timescale 1ns/1ps
module jril_loader (
  // core clock domain
  input  wire logic                           CORE_CLK,
  input  wire logic                           RESET_N,
  // link domain, from the access macro
  input  wire logic                           JTAG_SHIFT_CLOCK_TAP,
  input  wire logic                           JTAG_SERIAL_DATA_TAP,
  input  wire logic [jril_pkg::IR_W-1:0]      JTAG_USER_IR,
  input  wire logic                           JTAG_SHIFT_EN,
  // memory write port
  output logic      [jril_pkg::NBLK-1:0]      MEM_CS,
  output logic      [jril_pkg::ADDR_W-1:0]    MEM_WADDR,
  output logic      [jril_pkg::DATA_W-1:0]    MEM_WDATA,
  output logic                                MEM_WEN,
  output logic                                MEM_WCLK
);

  // write sequencer states
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_SETUP,
    WR_CLK_HI,
    WR_CLK_LO
  } jril_wr_state_t;

  // core reset release
  logic rst_s1_reg;   // first release stage
  logic rst_s2_reg;   // core reset, active low
  logic core_rst_n;   // copy used by the core logic

  // link reset release
  logic lrst_s1_reg;  // first release stage on jtag clock
  logic lrst_s2_reg;  // link reset, active low
  logic link_rst_n;   // copy used by the link logic

  // link domain state
  logic [jril_pkg::DATA_W-1:0] dsr_reg;   // data shift register
  logic [jril_pkg::LOC_W-1:0]  asr_reg;   // address shift register
  logic [jril_pkg::CNT_W-1:0]  cnt_reg;   // bits shifted so far
  logic [jril_pkg::PAY_W-1:0]  hold_reg;  // completed word, held
  logic                        tgl_reg;   // word event toggle
  logic                        shift_data;  // data opcode shifting
  logic                        shift_addr;  // address opcode shifting
  logic                        data_done;   // last data bit now
  logic                        addr_done;   // last address bit now

  // core domain state
  jril_wr_state_t              st_reg;     // sequencer state
  jril_wr_state_t              st_next;    // next state
  logic [jril_pkg::DATA_W-1:0] wdata_reg;  // pipelined write word
  logic [jril_pkg::ADDR_W-1:0] addr_reg;   // write address counter
  logic [jril_pkg::NBLK-1:0]   cs_reg;     // driven chip selects
  logic                        wen_reg;    // driven write enable
  logic                        wclk_reg;   // driven write clock
  logic                        pend_reg;   // data word waiting
  logic [jril_pkg::DATA_W-1:0] pend_data_reg;  // waiting data word
  logic [jril_pkg::NBLK-1:0]   blk_sel;    // current block, one-hot
  logic                        blk_step;   // move to next block
  logic                        blk_load;   // load block from address
  logic                        is_addr;    // received word kind
  logic                        word_done;  // end of a write cycle

  jril_word_if word_if ();  // carries words across the domains

  // reset handling

  // core reset: assert at once, release after two core edges
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  // core logic sees only the released copy
  assign core_rst_n = rst_s2_reg;

  // link reset: assert at once, release after two jtag edges
  always_ff @(posedge JTAG_SHIFT_CLOCK_TAP or negedge RESET_N) begin
    if (!RESET_N) begin
      lrst_s1_reg <= 1'b0;
      lrst_s2_reg <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_s2_reg <= lrst_s1_reg;
    end
  end
  // the link copy releases only once the jtag clock runs, so the
  // far side gives a few idle edges after reset before a frame
  assign link_rst_n = lrst_s2_reg;

  // link domain: jtag side

  // which opcode is shifting, decoded from the macro command
  assign shift_data = JTAG_SHIFT_EN &&
                      (JTAG_USER_IR == jril_pkg::OP_DATA);
  assign shift_addr = JTAG_SHIFT_EN &&
                      (JTAG_USER_IR == jril_pkg::OP_ADDR);

  // word boundaries, counted in jtag clock bits
  assign data_done = shift_data && (cnt_reg == jril_pkg::DATA_LAST);
  assign addr_done = shift_addr && (cnt_reg == jril_pkg::LOC_LAST);

  // data shift register, lsb first, jtag clock only
  always_ff @(posedge JTAG_SHIFT_CLOCK_TAP or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dsr_reg <= '0;
    end else if (shift_data) begin
      // serial bit enters at the top, word fills downward
      dsr_reg <= {JTAG_SERIAL_DATA_TAP,
                  dsr_reg[jril_pkg::DATA_W-1:1]};
    end
  end

  // address shift register under its own opcode
  always_ff @(posedge JTAG_SHIFT_CLOCK_TAP or negedge link_rst_n) begin
    if (!link_rst_n) begin
      asr_reg <= '0;
    end else if (shift_addr) begin
      // same order as the data register, lsb first
      asr_reg <= {JTAG_SERIAL_DATA_TAP,
                  asr_reg[jril_pkg::LOC_W-1:1]};
    end
  end

  // bit counter, restarts when shifting stops or a word ends
  always_ff @(posedge JTAG_SHIFT_CLOCK_TAP or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_reg <= jril_pkg::CNT_RESET;
    end else if (!(shift_data || shift_addr)) begin
      // a partial word is dropped when the shift ends; this takes
      // a jtag edge with shifting off, which the tap gives on its
      // way out of the shift state
      cnt_reg <= jril_pkg::CNT_RESET;
    end else if (data_done || addr_done) begin
      cnt_reg <= jril_pkg::CNT_RESET;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // hand a full word over; held until the next word completes
  always_ff @(posedge JTAG_SHIFT_CLOCK_TAP or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_reg <= '0;
      tgl_reg  <= 1'b0;
    end else if (data_done) begin
      // full data word including the bit arriving now
      hold_reg <= {1'b0, {(jril_pkg::LOC_W - jril_pkg::DATA_W){1'b0}},
                   JTAG_SERIAL_DATA_TAP,
                   dsr_reg[jril_pkg::DATA_W-1:1]};
      tgl_reg  <= ~tgl_reg;
    end else if (addr_done) begin
      // address word: kind bit set, block index above address
      hold_reg <= {1'b1, JTAG_SERIAL_DATA_TAP,
                   asr_reg[jril_pkg::LOC_W-1:1]};
      tgl_reg  <= ~tgl_reg;
    end
  end

  // link side of the crossing
  assign word_if.tgl      = tgl_reg;
  assign word_if.src_word = hold_reg;

  // crossing into the core clock

  // toggle handshake; the word stays still for a whole next word
  jril_xfer u_xfer (
    .clk   (CORE_CLK),
    .rst_n (core_rst_n),
    .w     (word_if)
  );

  // kind bit tells address words from data words
  assign is_addr = word_if.dst_word[jril_pkg::PAY_KIND];

  // core domain: memory side

  // block selects; address words load, counter wrap steps
  jril_csel u_csel (
    .clk      (CORE_CLK),
    .rst_n    (core_rst_n),
    .step     (blk_step),
    .load     (blk_load),
    .load_idx (word_if.dst_word[jril_pkg::LOC_W-1:jril_pkg::ADDR_W]),
    .sel      (blk_sel)
  );

  // address loads only between writes so a cycle never changes target
  assign blk_load  = word_if.vld && is_addr && (st_reg == WR_IDLE);
  assign word_done = (st_reg == WR_CLK_LO);
  assign blk_step  = word_done &&
                     (addr_reg == jril_pkg::ADDR_LAST);

  // a data word waits here until the sequencer is free
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= '0;
    end else if (word_if.vld && !is_addr) begin
      // a new word sets pending even while the old one is taken
      pend_reg      <= 1'b1;
      pend_data_reg <= word_if.dst_word[jril_pkg::DATA_W-1:0];
    end else if (st_reg == WR_IDLE) begin
      // taken by the sequencer as it leaves idle
      pend_reg <= 1'b0;
    end
  end

  // sequencer: setup, clock high, clock low, once per word
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      WR_IDLE: begin
        // start only for a whole data word
        if (pend_reg) begin
          st_next = WR_SETUP;
        end
      end
      WR_SETUP: begin
        // fields settle a cycle before the clock
        st_next = WR_CLK_HI;
      end
      WR_CLK_HI: begin
        // write clock high in this cycle
        st_next = WR_CLK_LO;
      end
      WR_CLK_LO: begin
        // fields held past the falling clock
        st_next = WR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st_reg <= WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // write word pipeline stage, stable over the whole cycle
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      wdata_reg <= '0;
    end else if (st_reg == WR_IDLE && pend_reg) begin
      // taken as the cycle starts, a cycle before the write clock
      wdata_reg <= pend_data_reg;
    end
  end

  // address: loaded by address word, else counts per write
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      addr_reg <= jril_pkg::ADDR_RESET;
    end else if (blk_load) begin
      // address word sets the next write target
      addr_reg <= word_if.dst_word[jril_pkg::ADDR_W-1:0];
    end else if (word_done) begin
      // wraps to zero as the select moves on
      addr_reg <= addr_reg + 9'h001;
    end
  end

  // select and enable: only the target block, only in a write
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cs_reg  <= '0;
      wen_reg <= 1'b0;
    end else if (st_reg == WR_IDLE && pend_reg) begin
      // start of a write cycle: target block only
      cs_reg  <= blk_sel;
      wen_reg <= 1'b1;
    end else if (word_done) begin
      // end of the write cycle
      cs_reg  <= '0;
      wen_reg <= 1'b0;
    end
  end

  // write clock rises a cycle after setup, falls a cycle later
  always_ff @(posedge CORE_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      wclk_reg <= 1'b0;
    end else begin
      // from a flip-flop so the memory sees a clean pulse
      wclk_reg <= (st_next == WR_CLK_HI);
    end
  end

  // memory ports, all from flip-flops; fabric writes use other ports
  assign MEM_CS    = cs_reg;
  assign MEM_WADDR = addr_reg;
  assign MEM_WDATA = wdata_reg;
  assign MEM_WEN   = wen_reg;
  assign MEM_WCLK  = wclk_reg;

endmodule

// ---- jril_loader_checker.sv ----
// checker of the memory write side of the jtag ram init loader
`timescale 1ns/1ps
module jril_loader_checker (
  input wire logic                        CORE_CLK,
  input wire logic                        RESET_N,
  input wire logic [jril_pkg::NBLK-1:0]   MEM_CS,
  input wire logic [jril_pkg::ADDR_W-1:0] MEM_WADDR,
  input wire logic [jril_pkg::DATA_W-1:0] MEM_WDATA,
  input wire logic                        MEM_WEN,
  input wire logic                        MEM_WCLK
);
  logic [jril_pkg::ADDR_W-1:0] addr_inc;  // address plus one, wraps
  assign addr_inc = MEM_WADDR + 9'h001;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // never two blocks selected
  a_cs_onehot: assert property (
    MEM_CS != 4'h0 |-> $onehot(MEM_CS)) else $error("two selects");
  // enable and select share one window
  a_wen_window: assert property (
    (MEM_CS != 4'h0) == MEM_WEN) else $error("enable outside select");
  // write clock framed by enable on both sides
  a_wclk_framed: assert property (
    MEM_WCLK |-> $past(MEM_WEN) ##1 MEM_WEN)
    else $error("write clock not framed");
  // one write clock pulse per write window
  a_write_seq: assert property (
    $rose(MEM_WEN) |-> !MEM_WCLK ##1 MEM_WCLK ##1 !MEM_WCLK ##1 !MEM_WEN)
    else $error("write pulse sequence wrong");
  // window lasts exactly three cycles
  a_wen_length: assert property (
    $rose(MEM_WEN) |-> MEM_WEN [*3] ##1 !MEM_WEN)
    else $error("write window length wrong");
  // fields steady inside the window
  a_fields_hold: assert property (
    MEM_WEN && $past(MEM_WEN) |->
      $stable(MEM_WDATA) && $stable(MEM_WADDR) && $stable(MEM_CS))
    else $error("write fields moved");
  // counter steps by one after each write
  a_addr_step: assert property (
    $fell(MEM_WEN) |-> MEM_WADDR == $past(addr_inc))
    else $error("address did not step");
  // no second write straight after a write
  a_quiet_gap: assert property (
    $fell(MEM_WEN) |-> !MEM_WEN [*8]) else $error("write repeated");
endmodule

bind jril_loader jril_loader_checker u_chk (
  .CORE_CLK  (CORE_CLK),
  .RESET_N   (RESET_N),
  .MEM_CS    (MEM_CS),
  .MEM_WADDR (MEM_WADDR),
  .MEM_WDATA (MEM_WDATA),
  .MEM_WEN   (MEM_WEN),
  .MEM_WCLK  (MEM_WCLK)
);

// ---- jril_far_model.sv ----
// jtag access macro and sram model around the loader
`timescale 1ns/1ps
module jril_far_model (
  output logic                            JTAG_SHIFT_CLOCK_TAP,
  output logic                            JTAG_SERIAL_DATA_TAP,
  output logic [jril_pkg::IR_W-1:0]       JTAG_USER_IR,
  output logic                            JTAG_SHIFT_EN,
  input  wire logic [jril_pkg::NBLK-1:0]   MEM_CS,
  input  wire logic [jril_pkg::ADDR_W-1:0] MEM_WADDR,
  input  wire logic [jril_pkg::DATA_W-1:0] MEM_WDATA,
  input  wire logic                        MEM_WEN,
  input  wire logic                        MEM_WCLK
);
  logic [23:0] wr_log [$];  // captured writes: enable, select, addr, data
  // link clock stands still low between frames
  initial begin
    JTAG_SHIFT_CLOCK_TAP = 1'b0;
    JTAG_SERIAL_DATA_TAP = 1'b0;
    JTAG_USER_IR         = 8'h00;
    JTAG_SHIFT_EN        = 1'b0;
  end
  // sram port: takes select, address, data on write clock
  always @(posedge MEM_WCLK) begin
    wr_log.push_back({2'h0, MEM_WEN, MEM_CS, MEM_WADDR, MEM_WDATA});
  end
  // one link period, data set while clock low
  task automatic tick(input logic bit_in);
    JTAG_SERIAL_DATA_TAP = bit_in;
    #62.5 JTAG_SHIFT_CLOCK_TAP = 1'b1;
    #62.5 JTAG_SHIFT_CLOCK_TAP = 1'b0;
  endtask
  // idle edges with shift off, line toggling
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      tick(~JTAG_SERIAL_DATA_TAP);
    end
  endtask
  // one shift frame, lsb first, instruction held throughout
  task automatic shift(input logic [15:0] v, input int n,
                       input logic [7:0] ir);
    JTAG_USER_IR  = ir;
    JTAG_SHIFT_EN = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(v[i]);
    end
    JTAG_SHIFT_EN = 1'b0;
    // exit and update edges with shifting off; line shows the inverse
    pulses(2);
  endtask
endmodule

// ---- jril_loader_tb_top.sv ----
// self-checking bench for the jtag ram init loader
`timescale 1ns/1ps
module jril_loader_tb_top;
  logic        core_clk;   // core clock, 20 ns
  logic        reset_n;    // async reset, low active
  logic        tck;        // link clock from model
  logic        tdi;        // serial data from model
  logic [7:0]  ir;         // user instruction
  logic        sh_en;      // shift window
  logic [3:0]  mem_cs;     // block selects
  logic [8:0]  mem_waddr;  // write address
  logic [7:0]  mem_wdata;  // write data
  logic        mem_wen;    // write enable
  logic        mem_wclk;   // write clock
  logic [3:0]  exp_cs;     // expected select of next write
  logic [8:0]  exp_addr;   // expected address of next write
  int          fail_count; // mismatches
  int          n_compared; // comparisons
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  jril_loader DUT (
    .CORE_CLK(core_clk), .RESET_N(reset_n),
    .JTAG_SHIFT_CLOCK_TAP(tck), .JTAG_SERIAL_DATA_TAP(tdi),
    .JTAG_USER_IR(ir), .JTAG_SHIFT_EN(sh_en), .MEM_CS(mem_cs),
    .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata),
    .MEM_WEN(mem_wen), .MEM_WCLK(mem_wclk));
  jril_far_model model (
    .JTAG_SHIFT_CLOCK_TAP(tck), .JTAG_SERIAL_DATA_TAP(tdi),
    .JTAG_USER_IR(ir), .JTAG_SHIFT_EN(sh_en), .MEM_CS(mem_cs),
    .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .MEM_WEN(mem_wen),
    .MEM_WCLK(mem_wclk));
  // verdict and end of run
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // value compare
  task automatic chk(input string name, input logic [23:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // shift one data word
  task automatic data_word(input logic [7:0] d);
    model.shift({8'h00, d}, 8, jril_pkg::OP_DATA);
  endtask
  // wait for a logged write and judge it, then advance expectation
  task automatic expect_write(input logic [7:0] d);
    int k;
    logic [23:0] got;
    for (k = 0; k < 200 && model.wr_log.size() == 0; k++) begin
      @(posedge core_clk);
    end
    if (model.wr_log.size() == 0) begin
      fail_count++;
      $display("[ERR] write expected 1 seen 0");
      stop_test();
    end
    got = model.wr_log.pop_front();
    chk("write", {2'h0, 1'b1, exp_cs, exp_addr, d}, got);
    if (exp_addr == jril_pkg::ADDR_LAST) begin
      exp_cs = {exp_cs[2:0], exp_cs[3]};
    end
    exp_addr = exp_addr + 9'h001;
  endtask
  // no write may appear
  task automatic expect_none;
    repeat (40) @(posedge core_clk);
    chk("write count", 24'h0, 24'(model.wr_log.size()));
  endtask
  // outputs quiet in reset
  task automatic sc_reset;
    chk("reset outputs", 24'h0,
        {1'b0, mem_wen, mem_wclk, mem_cs, mem_waddr, mem_wdata});
  endtask
  // one word, bit order, address step
  task automatic sc_data;
    data_word(8'h1E);
    expect_write(8'h1E);
    repeat (8) @(posedge core_clk);
    chk("next address", {15'h0, exp_addr}, {15'h0, mem_waddr});
  endtask
  // two words in one frame
  task automatic sc_back_to_back;
    model.shift({8'h6A, 8'h01}, 16, jril_pkg::OP_DATA);
    expect_write(8'h01);
    expect_write(8'h6A);
  endtask
  // loaded address at block end, then wrap onto next block
  task automatic sc_addr_wrap;
    for (int b = 2; b < 4; b++) begin
      model.shift({5'h00, 2'(b), 9'h1FF}, 11, jril_pkg::OP_ADDR);
      exp_cs = 4'h1 << b;
      exp_addr = 9'h1FF;
      expect_none();
      chk("loaded address", 24'h1FF, {15'h0, mem_waddr});
      data_word(8'h55);
      expect_write(8'h55);
      data_word(8'h2A);
      expect_write(8'h2A);
    end
  endtask
  // partial word dropped, counter untouched
  task automatic sc_abort;
    model.shift(16'h001F, 5, jril_pkg::OP_DATA);
    expect_none();
    data_word(8'hB4);
    expect_write(8'hB4);
  endtask
  // other instruction ignored
  task automatic sc_wrong_ir;
    model.shift(16'h00C7, 8, 8'h00);
    expect_none();
  endtask
  // run limit
  initial begin
    #1000000;
    fail_count++;
    $display("[ERR] run time expected end seen limit");
    stop_test();
  end
  // main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    exp_cs = 4'h1;
    exp_addr = 9'h000;
    reset_n = 1'b0;
    fork
      model.pulses(2);
      repeat (16) @(posedge core_clk);
    join
    sc_reset();
    #2 reset_n = 1'b1;
    model.pulses(3);
    repeat (4) @(posedge core_clk);
    sc_data();
    sc_back_to_back();
    sc_abort();
    sc_wrong_ir();
    sc_addr_wrap();
    stop_test();
  end
endmodule
